// ---- slf_pkg.sv ----
// Shared constants and state types for the status word and LIN flag bank
package slf_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int DOM_TIMEOUT_US = 10;
    localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;
    localparam int DOM_CNT_W = 16;
    localparam logic [DOM_CNT_W-1:0] DOM_TIMEOUT_CNT = DOM_TIMEOUT_CYC[DOM_CNT_W-1:0];

    // ------------------------------------------------------------------
    // Channels and SPI framing
    // ------------------------------------------------------------------
    localparam int N_LIN = 2;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
    localparam logic [1:0] CMD_WRITE = 2'b01;
    localparam logic [N_LIN-1:0][15:0] LIN_FAULT_CMD = {16'h2980, 16'h2780};
    localparam logic [N_LIN-1:0][15:0] LIN_WAKE_CMD = {16'h2880, 16'h2680};
    localparam logic [15:0] STATUS_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------------
    localparam int ST_INT = 15;
    localparam int ST_WAKE = 14;
    localparam int ST_RST = 13;
    localparam int ST_CAN_G = 12;
    localparam int ST_LIN_G = 11;
    localparam int ST_IO_G = 10;
    localparam int ST_SAFE_G = 9;
    localparam int ST_REG_G = 8;
    localparam int ST_CAN_BUS = 7;
    localparam int ST_CAN_LOC = 6;
    localparam int ST_FIRST_LIN_CHANNEL_SOURCE = 4;
    localparam int ST_IO_HI = 3;
    localparam int ST_IO_LO = 2;
    localparam int ST_REG_HI = 1;
    localparam int ST_REG_LO = 0;

    // ------------------------------------------------------------------
    // LIN fault byte layout and synchroniser vector layout
    // ------------------------------------------------------------------
    localparam int FB_DOM = 7;
    localparam int FB_TERM = 6;
    localparam int FB_OT = 5;
    localparam int FB_RXL = 4;
    localparam int FB_RXH = 3;
    localparam int FB_TXD = 2;
    localparam int FB_TRX = 1;
    localparam int FB_WAKE_RX = 0;
    localparam int SY_BUS_DOM = 0;
    localparam int SY_TERM = 2;
    localparam int SY_OT = 4;
    localparam int SY_RXL = 6;
    localparam int SY_RXH = 8;
    localparam int SY_TXD = 10;
    localparam int SY_WEVT = 12;
    localparam int SY_TRX = 14;
    localparam int SY_WEN = 16;
    localparam int SY_MOSI = 18;
    localparam int SY_CS_N = 19;
    localparam int SY_SCLK = 20;
    localparam int SY_W = 21;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {SPI_IDLE, SPI_XFER} slf_spi_state_type;

    typedef struct packed {
        logic dom;
        logic term;
        logic ot;
        logic rxl;
        logic rxh;
        logic txd;
        logic wake;
        logic wake_prev;
        logic [DOM_CNT_W-1:0] dom_cnt;
    } slf_chan_state_type;

    typedef struct packed {
        slf_spi_state_type st;
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic [2:0] spi_d3;
        logic [4:0] bit_cnt;
        logic [15:0] rx;
        logic [7:0] tx;
        logic [15:0] status;
        logic [N_LIN-1:0] clr_fault;
        logic [N_LIN-1:0] clr_wake;
    } slf_top_state_type;

endpackage

// ---- slf_lin_if.sv ----
// Bundle between the status logic and one LIN channel flag bank
`timescale 1ns/1ps
`default_nettype none
interface slf_lin_if;
    logic bus_dom;
    logic term_short;
    logic over_temp;
    logic rxd_low;
    logic rxd_high;
    logic txd_dom;
    logic wake_evt;
    logic trx_mode;
    logic wake_en;
    logic clr_fault;
    logic clr_wake;
    logic [7:0] fault_byte;
    logic wake_src;
    logic fault_pend;

    modport bank (
        input bus_dom, term_short, over_temp, rxd_low, rxd_high, txd_dom,
        input wake_evt, trx_mode, wake_en, clr_fault, clr_wake,
        output fault_byte, wake_src, fault_pend
    );
    modport ctrl (
        output bus_dom, term_short, over_temp, rxd_low, rxd_high, txd_dom,
        output wake_evt, trx_mode, wake_en, clr_fault, clr_wake,
        input fault_byte, wake_src, fault_pend
    );
endinterface
`default_nettype wire

// ---- slf_lin_chan.sv ----
// Flag bank of one LIN channel: latched faults, wake source, real-time state
`timescale 1ns/1ps
`default_nettype none
module slf_lin_chan (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    slf_lin_if.bank lif
);

    slf_pkg::slf_chan_state_type r;
    slf_pkg::slf_chan_state_type n;
    logic dom_hit;

    // Fault latch: condition sets, read clears only once the fault is gone
    function automatic logic fault_latch(input logic flag, input logic cond, input logic clr);
        fault_latch = cond | (flag & ~clr);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        dom_hit = (r.dom_cnt == slf_pkg::DOM_TIMEOUT_CNT);
        // Saturating timer so a long clamp never wraps back to clear
        if (!lif.bus_dom) begin
            n.dom_cnt = '0;
        end else if (!dom_hit) begin
            n.dom_cnt = r.dom_cnt + 16'h0001;
        end
        n.dom = fault_latch(r.dom, dom_hit, lif.clr_fault);
        n.term = fault_latch(r.term, lif.term_short, lif.clr_fault);
        n.ot = fault_latch(r.ot, lif.over_temp, lif.clr_fault);
        n.rxl = fault_latch(r.rxl, lif.rxd_low, lif.clr_fault);
        n.rxh = fault_latch(r.rxh, lif.rxd_high, lif.clr_fault);
        n.txd = fault_latch(r.txd, lif.txd_dom, lif.clr_fault);
        // Rising edge of the wake indication; a new event beats the clear
        n.wake_prev = lif.wake_evt;
        n.wake = (lif.wake_evt & ~r.wake_prev) | (r.wake & ~lif.clr_wake);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Real-time bits pass straight from the synchronised mode lines
    assign lif.fault_byte[slf_pkg::FB_DOM] = r.dom;
    assign lif.fault_byte[slf_pkg::FB_TERM] = r.term;
    assign lif.fault_byte[slf_pkg::FB_OT] = r.ot;
    assign lif.fault_byte[slf_pkg::FB_RXL] = r.rxl;
    assign lif.fault_byte[slf_pkg::FB_RXH] = r.rxh;
    assign lif.fault_byte[slf_pkg::FB_TXD] = r.txd;
    assign lif.fault_byte[slf_pkg::FB_TRX] = lif.trx_mode;
    assign lif.fault_byte[slf_pkg::FB_WAKE_RX] = lif.wake_en;
    assign lif.wake_src = r.wake;
    assign lif.fault_pend = r.dom | r.term | r.ot | r.rxl | r.rxh | r.txd;

endmodule
`default_nettype wire

// ---- slf_status_lin_flags.sv ----
// Top: SPI status word, LIN flag read-out and read-to-clear control
`timescale 1ns/1ps
`default_nettype none
module slf_status_lin_flags (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // SPI slave pins
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // LIN channel indications, one bit per channel
    input wire logic [1:0] i_lin_bus_dom,
    input wire logic [1:0] i_lin_term_short,
    input wire logic [1:0] i_lin_over_temp,
    input wire logic [1:0] i_lin_rxd_low,
    input wire logic [1:0] i_lin_rxd_high,
    input wire logic [1:0] i_lin_txd_dom,
    input wire logic [1:0] i_lin_wake_evt,
    input wire logic [1:0] i_lin_trx_mode,
    input wire logic [1:0] i_lin_wake_en,
    // Pending-flag summaries from the other flag banks
    input wire logic i_int_other_pend,
    input wire logic i_wake_other_pend,
    input wire logic i_rst_flags_pend,
    input wire logic i_can_bus_src,
    input wire logic i_can_loc_src,
    input wire logic i_io_hi_src,
    input wire logic i_io_lo_src,
    input wire logic i_safe_src,
    input wire logic i_reg_hi_src,
    input wire logic i_reg_lo_src,
    // Live copy of the status word
    output logic [15:0] o_status_word
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    slf_pkg::slf_top_state_type r;
    slf_pkg::slf_top_state_type n;
    logic [slf_pkg::SY_W-1:0] raw;
    logic [slf_pkg::N_LIN-1:0][7:0] fault_byte;
    logic [slf_pkg::N_LIN-1:0] wake_src;
    logic [slf_pkg::N_LIN-1:0] fault_pend;
    logic [slf_pkg::N_LIN-1:0] lin_pend;
    logic [15:0] status_calc;
    logic sclk_q;
    logic cs_n_q;
    logic mosi_q;
    logic sclk_rise;
    logic sclk_fall;

    // ------------------------------------------------------------------
    // Second byte selection
    // ------------------------------------------------------------------
    // The command type is known once the first byte is in, which is just
    // in time to choose what goes out in the second byte
    function automatic logic [7:0] second_byte(
        input logic [7:0] first,
        input logic [7:0] ext_status,
        input logic [slf_pkg::N_LIN-1:0][7:0] fbytes,
        input logic [slf_pkg::N_LIN-1:0] wsrc
    );
        second_byte = 8'h00;
        if (first[7:6] == slf_pkg::CMD_WRITE) begin
            second_byte = ext_status;
        end else begin
            // Reads carry register data, never the extended status
            for (int i = 0; i < slf_pkg::N_LIN; i++) begin
                if (first == slf_pkg::LIN_FAULT_CMD[i][15:8]) begin
                    second_byte = fbytes[i];
                end else if (first == slf_pkg::LIN_WAKE_CMD[i][15:8]) begin
                    second_byte = {7'h00, wsrc[i]};
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin bundle for the synchroniser
    // ------------------------------------------------------------------
    // Every SPI and LIN pin is asynchronous to the system clock, so all pass two stages;
    // select travels inverted so cleared stages read as deselected, not a frame
    assign raw = {i_spi_sclk, ~i_spi_cs_n, i_spi_mosi, i_lin_wake_en,
                  i_lin_trx_mode, i_lin_wake_evt, i_lin_txd_dom, i_lin_rxd_high,
                  i_lin_rxd_low, i_lin_over_temp, i_lin_term_short, i_lin_bus_dom};

    // Synchronised SPI pins, read only from the second stage onward
    assign sclk_q = r.s2[slf_pkg::SY_SCLK];
    assign cs_n_q = ~r.s2[slf_pkg::SY_CS_N];
    assign mosi_q = r.s2[slf_pkg::SY_MOSI];
    assign sclk_rise = sclk_q & ~r.spi_d3[2];
    assign sclk_fall = ~sclk_q & r.spi_d3[2];

    // ------------------------------------------------------------------
    // LIN channel banks
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < slf_pkg::N_LIN; gi++) begin : g_chan
            slf_lin_if u_if ();

            // Synchronised indications into the bank
            assign u_if.bus_dom = r.s2[slf_pkg::SY_BUS_DOM + gi];
            assign u_if.term_short = r.s2[slf_pkg::SY_TERM + gi];
            assign u_if.over_temp = r.s2[slf_pkg::SY_OT + gi];
            assign u_if.rxd_low = r.s2[slf_pkg::SY_RXL + gi];
            assign u_if.rxd_high = r.s2[slf_pkg::SY_RXH + gi];
            assign u_if.txd_dom = r.s2[slf_pkg::SY_TXD + gi];
            assign u_if.wake_evt = r.s2[slf_pkg::SY_WEVT + gi];
            assign u_if.trx_mode = r.s2[slf_pkg::SY_TRX + gi];
            assign u_if.wake_en = r.s2[slf_pkg::SY_WEN + gi];
            assign u_if.clr_fault = r.clr_fault[gi];
            assign u_if.clr_wake = r.clr_wake[gi];

            // Results back from the bank
            assign fault_byte[gi] = u_if.fault_byte;
            assign wake_src[gi] = u_if.wake_src;
            assign fault_pend[gi] = u_if.fault_pend;
            assign lin_pend[gi] = u_if.fault_pend | u_if.wake_src;

            slf_lin_chan u_chan (
                .i_clk_sys(i_clk_sys),
                .i_sys_rst(i_sys_rst),
                .lif(u_if.bank)
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    // Pure function of the pending flags, so each bit falls by itself as
    // soon as the last flag under it has been read away
    always_comb begin
        status_calc = slf_pkg::STATUS_RST;
        status_calc[slf_pkg::ST_INT] = i_int_other_pend | (|fault_pend);
        status_calc[slf_pkg::ST_WAKE] = i_wake_other_pend | (|wake_src);
        status_calc[slf_pkg::ST_RST] = i_rst_flags_pend;
        status_calc[slf_pkg::ST_CAN_G] = i_can_bus_src | i_can_loc_src;
        status_calc[slf_pkg::ST_LIN_G] = |lin_pend;
        status_calc[slf_pkg::ST_IO_G] = i_io_hi_src | i_io_lo_src;
        status_calc[slf_pkg::ST_SAFE_G] = i_safe_src;
        status_calc[slf_pkg::ST_REG_G] = i_reg_hi_src | i_reg_lo_src;
        status_calc[slf_pkg::ST_CAN_BUS] = i_can_bus_src;
        status_calc[slf_pkg::ST_CAN_LOC] = i_can_loc_src;
        status_calc[slf_pkg::ST_FIRST_LIN_CHANNEL_SOURCE +: slf_pkg::N_LIN] = lin_pend;
        status_calc[slf_pkg::ST_IO_HI] = i_io_hi_src;
        status_calc[slf_pkg::ST_IO_LO] = i_io_lo_src;
        status_calc[slf_pkg::ST_REG_HI] = i_reg_hi_src;
        status_calc[slf_pkg::ST_REG_LO] = i_reg_lo_src;
    end

    // ------------------------------------------------------------------
    // Next state: synchroniser, SPI shifter, read-to-clear decode
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.s1 = raw;
        n.s2 = r.s1;
        n.spi_d3 = r.s2[slf_pkg::SY_SCLK:slf_pkg::SY_MOSI];
        n.status = status_calc;
        // Clear strobes last exactly one cycle
        n.clr_fault = '0;
        n.clr_wake = '0;
        case (r.st)
            slf_pkg::SPI_IDLE: begin
                if (!cs_n_q) begin
                    // Mode 0: first bit of the fixed status is out before any edge
                    n.st = slf_pkg::SPI_XFER;
                    n.bit_cnt = '0;
                    n.rx = '0;
                    n.tx = r.status[15:8];
                end
            end
            slf_pkg::SPI_XFER: begin
                if (cs_n_q) begin
                    n.st = slf_pkg::SPI_IDLE;
                    // Only a complete 16-bit frame counts as a flag read
                    if (r.bit_cnt == slf_pkg::FRAME_BITS) begin
                        for (int i = 0; i < slf_pkg::N_LIN; i++) begin
                            // Real-time bits have no latch, so nothing clears them
                            if (r.rx == slf_pkg::LIN_FAULT_CMD[i]) begin
                                n.clr_fault[i] = 1'b1;
                            end
                            if (r.rx == slf_pkg::LIN_WAKE_CMD[i]) begin
                                n.clr_wake[i] = 1'b1;
                            end
                        end
                    end
                end else begin
                    if (sclk_rise) begin
                        n.rx = {r.rx[14:0], mosi_q};
                        if (r.bit_cnt != slf_pkg::BIT_CNT_MAX) begin
                            n.bit_cnt = r.bit_cnt + 5'h01;
                        end
                    end
                    if (sclk_fall) begin
                        if (r.bit_cnt == slf_pkg::BYTE_BITS) begin
                            n.tx = second_byte(r.rx[7:0], r.status[7:0], fault_byte, wake_src);
                        end else begin
                            // Beyond the second byte the line shifts zeros
                            n.tx = {r.tx[6:0], 1'b0};
                        end
                    end
                end
            end
            default: begin
                n.st = slf_pkg::SPI_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Output enable follows the synchronised select, two to three cycles late
    assign o_spi_miso = r.tx[7];
    assign o_spi_miso_oe = (r.st == slf_pkg::SPI_XFER);
    assign o_status_word = r.status;

endmodule
`default_nettype wire

// ---- slf_status_lin_flags_end.sv ----
// Spare design file; all logic of the block lives in the other files

// ---- slf_spi_master.sv ----
// SPI master model that drives mode 0 frames into the status block
`timescale 1ns/1ps
`default_nettype none
module slf_spi_master (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    // Ten clocks a half period keeps sclk at 5 MHz, inside the sync limit
    localparam int HALF = 10;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Whole 16-bit frame, MSB first, reply captured on each rising sclk
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        rsp = 16'h0000;
        @(negedge i_clk) o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_mosi = cmd[i];
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b1;
            rsp[i] = i_miso;
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (6) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // Idle data carries no meaning
        repeat (6) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// ---- slf_status_lin_flags_chk.sv ----
// Port checker for the status word and the SPI output enable
`timescale 1ns/1ps
`default_nettype none
module slf_status_chk (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_spi_cs_n,
    input wire logic o_spi_miso_oe,
    input wire logic i_int_other_pend,
    input wire logic i_wake_other_pend,
    input wire logic i_rst_flags_pend,
    input wire logic i_can_bus_src,
    input wire logic i_can_loc_src,
    input wire logic i_io_hi_src,
    input wire logic i_io_lo_src,
    input wire logic i_safe_src,
    input wire logic i_reg_hi_src,
    input wire logic i_reg_lo_src,
    input wire logic [15:0] o_status_word
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------
    // Frame phases
    // ------------------------------------------------------------
    sequence s_sel;
        $fell(i_spi_cs_n) ##1 (!i_spi_cs_n) [*4];
    endsequence
    sequence s_idle;
        i_spi_cs_n [*5];
    endsequence
    // ------------------------------------------------------------
    // Status word, one cycle behind its sources
    // ------------------------------------------------------------
    a_int_flag: assert property (i_int_other_pend |=> o_status_word[15])
        else $error("int pending bit missing");
    a_wake_flag: assert property (i_wake_other_pend |=> o_status_word[14])
        else $error("wake pending bit missing");
    a_rst_flag: assert property (
        !$past(i_sys_rst) |-> o_status_word[13] == $past(i_rst_flags_pend))
        else $error("reset pending bit wrong");
    a_group_bits: assert property (
        !$past(i_sys_rst) |-> o_status_word[12:6] == {
        $past(i_can_bus_src) | $past(i_can_loc_src), o_status_word[5] | o_status_word[4],
        $past(i_io_hi_src) | $past(i_io_lo_src), $past(i_safe_src),
        $past(i_reg_hi_src) | $past(i_reg_lo_src), $past(i_can_bus_src), $past(i_can_loc_src)})
        else $error("group bits wrong");
    a_io_bits: assert property (
        !$past(i_sys_rst) |-> o_status_word[3:2] == {$past(i_io_hi_src), $past(i_io_lo_src)})
        else $error("io source bits wrong");
    a_reg_bits: assert property (
        !$past(i_sys_rst) |-> o_status_word[1:0] == {$past(i_reg_hi_src), $past(i_reg_lo_src)})
        else $error("regulator source bits wrong");
    // Without LIN pending, summary bits must fall back to the outside sources
    a_int_selfclr: assert property (
        o_status_word[15] && !o_status_word[11] |-> $past(i_int_other_pend))
        else $error("int bit stuck");
    a_wake_selfclr: assert property (
        o_status_word[14] && !o_status_word[11] |-> $past(i_wake_other_pend))
        else $error("wake bit stuck");
    a_oe_frame: assert property (s_sel |-> o_spi_miso_oe)
        else $error("miso not driven in frame");
    a_oe_idle: assert property (s_idle |-> !o_spi_miso_oe)
        else $error("miso driven while idle");
    // Cleared select stages must not look like a frame start
    a_oe_reset: assert property (
        $fell(i_sys_rst) |-> !o_spi_miso_oe ##1 !o_spi_miso_oe)
        else $error("miso driven after reset");
endmodule
bind slf_status_lin_flags slf_status_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_spi_cs_n(i_spi_cs_n),
    .o_spi_miso_oe(o_spi_miso_oe), .i_int_other_pend(i_int_other_pend),
    .i_wake_other_pend(i_wake_other_pend), .i_rst_flags_pend(i_rst_flags_pend),
    .i_can_bus_src(i_can_bus_src), .i_can_loc_src(i_can_loc_src), .i_io_hi_src(i_io_hi_src),
    .i_io_lo_src(i_io_lo_src), .i_safe_src(i_safe_src), .i_reg_hi_src(i_reg_hi_src),
    .i_reg_lo_src(i_reg_lo_src), .o_status_word(o_status_word)
);
`default_nettype wire

// ---- tb_spi_status_and_lin_flags.sv ----
// Self-checking bench for the status word and LIN flag bank
`timescale 1ns/1ps
`default_nettype none
module tb_spi_status_and_lin_flags;
    logic clk, rst, sclk, cs_n, mosi, miso, oe;
    logic [1:0] cause [6];
    logic [1:0] wevt, trx, wen;
    logic [9:0] side;
    logic [15:0] sw, rsp, e;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int lat [2][6] = '{default: 0};
    int ws [2] = '{default: 0};
    slf_status_lin_flags i_dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe),
        .i_lin_bus_dom(cause[0]), .i_lin_term_short(cause[1]), .i_lin_over_temp(cause[2]),
        .i_lin_rxd_low(cause[3]), .i_lin_rxd_high(cause[4]), .i_lin_txd_dom(cause[5]),
        .i_lin_wake_evt(wevt), .i_lin_trx_mode(trx), .i_lin_wake_en(wen),
        .i_int_other_pend(side[9]), .i_wake_other_pend(side[8]), .i_rst_flags_pend(side[7]),
        .i_can_bus_src(side[6]), .i_can_loc_src(side[5]), .i_io_hi_src(side[4]),
        .i_io_lo_src(side[3]), .i_safe_src(side[2]), .i_reg_hi_src(side[1]),
        .i_reg_lo_src(side[0]), .o_status_word(sw)
    );
    slf_spi_master i_mst (.i_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_st();
        logic [1:0] p;
        int anyf;
        anyf = 0;
        for (int c = 0; c < 2; c++) begin
            p[c] = (ws[c] != 0);
            for (int f = 0; f < 6; f++) begin
                p[c] = p[c] | (lat[c][f] != 0);
                anyf = anyf | lat[c][f];
            end
        end
        return {side[9] | (anyf != 0), side[8] | (ws[0] + ws[1] != 0), side[7], side[6] | side[5],
            |p, side[4] | side[3], side[2], side[1] | side[0], side[6], side[5], p,
            side[4], side[3], side[1], side[0]};
    endfunction
    // Fault byte: latched flags on top, live state bits below
    function automatic logic [7:0] fb(int c);
        logic [7:0] b;
        for (int f = 0; f < 6; f++) begin
            b[7 - f] = (lat[c][f] != 0);
        end
        b[1] = trx[c];
        b[0] = wen[c];
        return b;
    endfunction
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
        check_count++;
        if (g !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic fault_rd(input int c, input string nm);
        e = exp_st();
        i_mst.xfer(c != 0 ? 16'h2980 : 16'h2780, rsp);
        chk(nm, {e[15:8], fb(c)}, rsp);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Bound well above the roughly 30k cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            error_cnt++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        for (int f = 0; f < 6; f++) begin
            cause[f] = 2'b00;
        end
        wevt = 2'b00;
        trx = 2'b00;
        wen = 2'b00;
        side = 10'h000;
        void'($urandom(92));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("status after reset", 16'h0000, sw);
        // Random source mix against both reply forms and the live bits
        for (int i = 0; i < 12; i++) begin
            side = 10'($urandom());
            trx = 2'($urandom());
            wen = 2'($urandom());
            repeat (4) @(negedge clk);
            e = exp_st();
            chk("status word", e, sw);
            i_mst.xfer(16'h4000 | 16'($urandom_range(0, 16383)), rsp);
            chk("write reply", e, rsp);
            i_mst.xfer(i[0] ? 16'hc100 : 16'h0100, rsp);
            chk("read reply", {e[15:8], 8'h00}, rsp);
            fault_rd(i % 2, "live state bits");
        end
        side = 10'h000;
        // Each latched fault: held, recovered, then read away
        for (int c = 0; c < 2; c++) begin
            for (int f = 0; f < 6; f++) begin
                cause[f][c] = 1'b1;
                if (f == 0) begin
                    repeat (990) @(negedge clk);
                    chk("clamp before timeout", exp_st(), sw);
                end
                repeat (f == 0 ? 30 : 6) @(negedge clk);
                lat[c][f] = 1;
                chk("fault status", exp_st(), sw);
                fault_rd(c, "fault held");
                cause[f][c] = 1'b0;
                repeat (6) @(negedge clk);
                fault_rd(c, "fault recovered");
                lat[c][f] = 0;
                repeat (4) @(negedge clk);
                chk("fault cleared", exp_st(), sw);
                fault_rd(c, "fault after read");
            end
        end
        // Wake source per channel, untouched by a fault read
        for (int c = 0; c < 2; c++) begin
            wevt[c] = 1'b1;
            repeat (6) @(negedge clk);
            ws[c] = 1;
            chk("wake status", exp_st(), sw);
            fault_rd(c, "fault read with wake");
            e = exp_st();
            i_mst.xfer(c != 0 ? 16'h2880 : 16'h2680, rsp);
            chk("wake read", {e[15:8], 8'h01}, rsp);
            ws[c] = 0;
            wevt[c] = 1'b0;
            repeat (4) @(negedge clk);
            chk("wake cleared", exp_st(), sw);
        end
        final_report();
    end
endmodule
`default_nettype wire
